//--- testbench/spimc_asserts.sv
// Purpose: Port checks for the serial port block
// Assumes: Only top-level ports are visible
// Notes: Bound to spimc_core after the module
`timescale 1ns/1ps
`default_nettype none
module spimc_asserts
	import spimc_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_irq,
	input wire logic i_ss_n,
	input wire logic o_sck,
	input wire logic o_sck_oe,
	input wire logic o_mosi_oe,
	input wire logic o_miso_oe,
	input wire logic o_port_enable
);
	logic [11:0] since_wr;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	// Cycles since the last data write, saturating
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			since_wr <= 12'hFFF;
		end else if (i_wr && i_addr == SPIMC_OFS_DATA) begin
			since_wr <= 12'h000;
		end else if (since_wr != 12'hFFF) begin
			since_wr <= since_wr + 12'h001;
		end
	end
	property p_rst_quiet;
		$fell(i_sys_rst) |-> !o_port_enable && !o_irq;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("port or irq active after reset");
	property p_ctrl_rst;
		$past(i_sys_rst, 2) && i_rd && i_addr == SPIMC_OFS_CTRL
			|=> o_rdata[7:4] == SPIMC_CR_UPPER_RST;
	endproperty
	a_ctrl_rst: assert property (p_ctrl_rst)
		else $error("control upper bits not zero after reset");
	property p_stat_rst;
		$past(i_sys_rst, 4) && i_rd && i_addr == SPIMC_OFS_STAT
			|=> o_rdata == SPIMC_SR_RST;
	endproperty
	a_stat_rst: assert property (p_stat_rst)
		else $error("status not zero after reset");
	property p_stat_unused;
		i_rd && i_addr == SPIMC_OFS_STAT |=> !o_rdata[5] && o_rdata[3:0] == 4'h0;
	endproperty
	a_stat_unused: assert property (p_stat_unused)
		else $error("unused status bits read nonzero");
	property p_idle_off;
		!o_port_enable |-> !o_sck_oe && !o_mosi_oe && !o_miso_oe;
	endproperty
	a_idle_off: assert property (p_idle_off)
		else $error("pin driven while port disabled");
	property p_master_pins;
		o_sck_oe |-> o_mosi_oe && !o_miso_oe;
	endproperty
	a_master_pins: assert property (p_master_pins)
		else $error("master pin directions wrong");
	property p_fault_drop;
		(o_sck_oe && !i_ss_n) [*3] |-> ##[0:4] (!o_port_enable && !o_sck_oe);
	endproperty
	a_fault_drop: assert property (p_fault_drop)
		else $error("select low as master did not drop the port");
	property p_sck_cause;
		o_sck_oe && $past(o_sck_oe) && o_sck != $past(o_sck) && !$past(i_wr)
			|-> since_wr < 12'hA28;
	endproperty
	a_sck_cause: assert property (p_sck_cause)
		else $error("clock moved without a data write");
endmodule
bind spimc_core spimc_asserts u_asserts (.i_clock(i_clock),
	.i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .o_irq(o_irq), .i_ss_n(i_ss_n), .o_sck(o_sck),
	.o_sck_oe(o_sck_oe), .o_mosi_oe(o_mosi_oe), .o_miso_oe(o_miso_oe),
	.o_port_enable(o_port_enable));
`default_nettype wire

//--- testbench/spimc_slave_model.sv
// Purpose: Far-end serial slave, idle-low clock, first-edge capture
// Assumes: Selected whenever the block drives the clock
// Notes: Always answers 8'hA5; released line shows the inverse bit
`timescale 1ns/1ps
`default_nettype none
module spimc_slave_model (
	input wire logic i_sck,
	input wire logic i_mosi,
	input wire logic i_sel,
	output logic o_miso,
	output logic [7:0] o_rx
);
	logic [7:0] tx = 8'hA5;
	int cnt = 0;
	// Capture on the rising edge, MSB first
	always @(posedge i_sck) begin
		if (i_sel) begin
			o_rx <= {o_rx[6:0], i_mosi};
			cnt <= cnt + 1;
		end
	end
	// Next bit on the falling edge, reload per byte
	always @(negedge i_sck) begin
		if (i_sel) begin
			tx <= (cnt % 8 == 0) ? 8'hA5 : {tx[6:0], 1'b0};
		end
	end
	// Deselected line never holds the last value
	assign o_miso = i_sel ? tx[7] : ~tx[7];
endmodule
`default_nettype wire

//--- testbench/tb_spi_master_slave_control_regs.sv
// Purpose: Register-level tests of the serial port block
// Assumes: Far slave answers 8'hA5 with idle-low clock
// Notes: Clock divisors checked by sampling the serial clock
`timescale 1ns/1ps
`default_nettype none
module tb_spi_master_slave_control_regs
	import spimc_pkg::*;
;
	localparam logic [7:0] AD = SPIMC_OFS_DATA;
	localparam logic [7:0] AC = SPIMC_OFS_CTRL;
	localparam logic [7:0] AS = SPIMC_OFS_STAT;
	logic i_clock, i_sys_rst, i_wr, i_rd, i_ss_n, o_irq, o_sck, o_sck_oe;
	logic o_mosi, o_mosi_oe, o_port_enable, miso;
	logic [7:0] i_addr, i_wdata, o_rdata, rx;
	logic [2:0] codes [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
	int divs [6] = '{2, 8, 16, 32, 64, 128};
	int errors, comparisons, n;
	spimc_core u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .o_irq(o_irq), .i_sck(1'b0), .i_mosi(1'b0),
		.i_miso(miso), .i_ss_n(i_ss_n), .o_sck(o_sck), .o_sck_oe(o_sck_oe),
		.o_mosi(o_mosi), .o_mosi_oe(o_mosi_oe), .o_miso(), .o_miso_oe(),
		.o_port_enable(o_port_enable));
	spimc_slave_model u_far (.i_sck(o_sck), .i_mosi(o_mosi),
		.i_sel(o_sck_oe), .o_miso(miso), .o_rx(rx));
	task automatic chk(input logic [7:0] seen, exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	task automatic rdc(input logic [7:0] a, exp, input string what);
		logic [7:0] d;
		rd(a, d);
		chk(d, exp, what);
	endtask
	// Poll status until the done flag shows
	task automatic wait_done();
		logic [7:0] s;
		int k;
		s = 8'h00;
		for (k = 0; k < 1500 && s[7] !== 1'b1; k++) rd(AS, s);
	endtask
	// Clock cycles between two rising serial clock edges
	task automatic sck_period(output int p);
		int c, s, k;
		logic q;
		c = 0;
		s = 0;
		k = 0;
		q = o_sck;
		while (k < 2 && c < 600) begin
			@(posedge i_clock);
			#1 c++;
			if (o_sck && !q) begin
				k++;
				if (k == 1) s = c;
			end
			q = o_sck;
		end
		p = c - s;
	endtask
	task automatic final_report();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end
	initial begin
		#(25 * 90000);
		errors++;
		final_report();
	end
	initial begin
		{errors, comparisons} = 0;
		{i_sys_rst, i_wr, i_rd, i_addr, i_wdata, i_ss_n} = 20'h80001;
		repeat (16) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		rdc(AC, 8'h00, "ctrl reset");
		rdc(AS, 8'h00, "stat reset");
		chk(o_port_enable, 8'h00, "port reset");
		wr(AC, 8'hF0);
		rdc(AC, 8'hF0, "ctrl rw");
		chk(o_port_enable, 8'h01, "port on");
		wr(AD, 8'h3C);
		wr(AD, 8'h55);
		wait_done();
		chk(o_irq, 8'h01, "irq done");
		rdc(AS, 8'hC0, "stat done");
		chk(rx, 8'h3C, "far rx");
		rdc(AD, 8'hA5, "rx buf");
		rdc(AS, 8'h00, "stat clear");
		for (int i = 0; i < 6; i++) begin
			wr(AC, {2'b11, codes[i][2], 1'b1, 2'b00, codes[i][1:0]});
			wr(AD, 8'h96);
			sck_period(n);
			chk(n[7:0], divs[i][7:0], "sck period");
			wait_done();
			rdc(AD, 8'hA5, "rx loop");
			chk(rx, 8'h96, "far loop");
		end
		@(posedge i_clock);
		i_ss_n <= 1'b0;
		repeat (6) @(posedge i_clock);
		i_ss_n <= 1'b1;
		repeat (4) @(posedge i_clock);
		#1 chk(o_port_enable, 8'h00, "fault off");
		chk(o_irq, 8'h01, "irq fault");
		wr(AC, 8'hD0);
		chk(o_port_enable, 8'h00, "refused");
		rdc(AS, 8'h10, "fault");
		wr(AC, 8'hD0);
		rdc(AS, 8'h00, "fault clear");
		chk(o_port_enable, 8'h01, "restored");
		wr(AC, 8'h58);
		chk(o_sck, 8'h01, "idle high");
		rdc(8'h30, 8'h00, "unmapped");
		final_report();
	end
endmodule
`default_nettype wire

//--- verilog/spimc_core.sv
// Purpose: Serial port (master/slave) with control, status, data regs
// Assumes: Pins pass through two flip-flops; register port is 8 bits
// Notes: Master SCK half period comes from a divide enable pulse
`timescale 1ns/1ps
`default_nettype none
module spimc_core
	import spimc_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic o_irq,
	input wire logic i_sck,
	input wire logic i_mosi,
	input wire logic i_miso,
	input wire logic i_ss_n,
	output logic o_sck,
	output logic o_sck_oe,
	output logic o_mosi,
	output logic o_mosi_oe,
	output logic o_miso,
	output logic o_miso_oe,
	output logic o_port_enable
);
	// Control register fields
	logic irq_en, port_en, half_dis, master, idle_lvl, capt_edge;
	logic [1:0] rate;
	// Status flags and sequence trackers
	logic done_flag, write_collision_flag_flag, mode_fault_flag_flag;
	logic stat_seen, mode_fault_flag_seen;
	// Shift engine
	spimc_state_t state;
	logic [7:0] shreg, rxbuf;
	logic [3:0] edge_cnt;
	logic [6:0] div_cnt;
	logic sck_int, tick, first_edge_pending;
	// Receive path, realigned to the synchronised data pin
	logic [7:0] rx_sh;
	logic [1:0] cap_d, fin_d;
	// Synchronisers
	logic [1:0] sck_s, mosi_s, miso_s, ss_s;
	logic sck_d;

	// Half-period length in cycles, minus one, from the rate code
	function automatic logic [6:0] half_len(input logic d, input logic [1:0] r);
		case ({d, r})
			3'b100: half_len = 7'h00; // /2
			3'b000: half_len = 7'h03; // /8
			3'b001: half_len = 7'h07; // /16
			3'b110: half_len = 7'h0F; // /32
			3'b010: half_len = 7'h1F; // /64
			3'b011: half_len = 7'h3F; // /128
			default: half_len = 7'h1F;
		endcase
	endfunction

	wire wr_data = i_wr && (i_addr == SPIMC_OFS_DATA);
	wire rd_data = i_rd && (i_addr == SPIMC_OFS_DATA);
	wire wr_ctrl = i_wr && (i_addr == SPIMC_OFS_CTRL);
	wire acc_stat = (i_wr || i_rd) && (i_addr == SPIMC_OFS_STAT);
	wire ss_low = !ss_s[1];
	wire fault_ev = port_en && master && ss_low;
	wire shifting = (state == SPIMC_SHIFT);
	// Busy until the delayed end of a master byte lands
	wire busy = shifting || (fin_d != 2'b00);
	wire slave_frozen = !master && port_en && ss_low;
	wire load_ok = wr_data && !done_flag && !busy && !slave_frozen;
	wire collide = wr_data && !done_flag && (busy || slave_frozen);
	wire data_clr = stat_seen && (wr_data || rd_data);
	wire sck_rise = sck_s[1] && !sck_d;
	wire sck_fall = !sck_s[1] && sck_d;
	wire sl_edge = port_en && !master && ss_low && (sck_rise || sck_fall);
	wire m_edge = shifting && master && tick;
	wire shift_edge = m_edge || sl_edge;
	wire sd_in = master ? miso_s[1] : mosi_s[1];
	// Sample on odd edges for phase 0, even edges for phase 1
	wire is_capture = (edge_cnt[0] == capt_edge);
	wire last_edge = (edge_cnt == 4'hF);
	// Launch edges move the next transmit bit; the very first is skipped
	wire is_launch = !is_capture && (edge_cnt != 4'h0);
	// Master captures lag two cycles to match the pin synchroniser
	wire cap_now = master ? cap_d[1] : (sl_edge && is_capture);
	wire fin_now = master ? fin_d[1] : (sl_edge && last_edge);

	// Pin synchronisers
	always_ff @(posedge i_clock) begin
		sck_s <= {sck_s[0], i_sck};
		mosi_s <= {mosi_s[0], i_mosi};
		miso_s <= {miso_s[0], i_miso};
		ss_s <= {ss_s[0], i_ss_n};
		sck_d <= sck_s[1];
	end

	// Control register
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			{irq_en, port_en, half_dis, master} <= SPIMC_CR_UPPER_RST;
			{idle_lvl, capt_edge, rate} <= SPIMC_CR_LOWER_RST;
		end else if (fault_ev) begin
			port_en <= 1'b0;
			master <= 1'b0;
		end else if (wr_ctrl) begin
			irq_en <= i_wdata[SPIMC_CR_IRQ_EN];
			half_dis <= i_wdata[SPIMC_CR_HALF_DIS];
			idle_lvl <= i_wdata[SPIMC_CR_IDLE_LVL];
			capt_edge <= i_wdata[SPIMC_CR_CAPT_EDGE];
			rate <= {i_wdata[SPIMC_CR_RATE_HI], i_wdata[SPIMC_CR_RATE_LO]};
			// Setting only allowed with no fault or as the clearing write
			if (!mode_fault_flag_flag || mode_fault_flag_seen) begin
				port_en <= i_wdata[SPIMC_CR_PORT_EN];
				master <= i_wdata[SPIMC_CR_MASTER];
			end else begin
				port_en <= port_en & i_wdata[SPIMC_CR_PORT_EN];
				master <= master & i_wdata[SPIMC_CR_MASTER];
			end
		end
	end

	// Status access trackers for the clearing sequences
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			stat_seen <= 1'b0;
			mode_fault_flag_seen <= 1'b0;
		end else begin
			if (acc_stat)
				stat_seen <= 1'b1;
			else if (wr_data || rd_data)
				stat_seen <= 1'b0;
			if (acc_stat && mode_fault_flag_flag)
				mode_fault_flag_seen <= 1'b1;
			else if (wr_ctrl)
				mode_fault_flag_seen <= 1'b0;
		end
	end

	// Status flags: hardware set wins over the clearing access
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			{done_flag, write_collision_flag_flag, mode_fault_flag_flag} <= 3'h0;
		end else begin
			if (fin_now)
				done_flag <= 1'b1;
			else if (data_clr)
				done_flag <= 1'b0;
			if (collide)
				write_collision_flag_flag <= 1'b1;
			else if (data_clr)
				write_collision_flag_flag <= 1'b0;
			if (fault_ev)
				mode_fault_flag_flag <= 1'b1;
			else if (wr_ctrl && mode_fault_flag_seen)
				mode_fault_flag_flag <= 1'b0;
		end
	end

	// Master bit-rate tick, ignored in slave mode
	always_ff @(posedge i_clock) begin
		if (i_sys_rst || !shifting || !master) begin
			div_cnt <= 7'h00;
			tick <= 1'b0;
		end else if (div_cnt >= half_len(half_dis, rate)) begin
			div_cnt <= 7'h00;
			tick <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 7'h01;
			tick <= 1'b0;
		end
	end

	// Shift engine: 16 clock edges per byte, MSB first
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			state <= SPIMC_IDLE;
			shreg <= SPIMC_BYTE_RST;
			edge_cnt <= 4'h0;
			sck_int <= 1'b0;
			first_edge_pending <= 1'b0;
		end else begin
			case (state)
				SPIMC_IDLE: begin
					sck_int <= 1'b0;
					edge_cnt <= 4'h0;
					if (load_ok) begin
						shreg <= i_wdata;
						if (master && port_en)
							state <= SPIMC_SHIFT;
					end else if (sl_edge) begin
						state <= SPIMC_SHIFT;
						edge_cnt <= 4'h1;
					end
				end
				SPIMC_SHIFT: begin
					if (shift_edge) begin
						sck_int <= !sck_int;
						edge_cnt <= edge_cnt + 4'h1;
						if (is_launch)
							shreg <= {shreg[6:0], 1'b0};
						if (last_edge)
							state <= SPIMC_IDLE;
					end else if (!port_en || (!master && !ss_low)) begin
						state <= SPIMC_IDLE;
					end
				end
				default: state <= SPIMC_IDLE;
			endcase
		end
	end

	// Capture pipeline and receive shifter, MSB first
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			cap_d <= 2'b00;
			fin_d <= 2'b00;
			rx_sh <= SPIMC_BYTE_RST;
		end else begin
			cap_d <= {cap_d[0], m_edge && is_capture};
			fin_d <= {fin_d[0], m_edge && last_edge};
			if (cap_now)
				rx_sh <= {rx_sh[6:0], sd_in};
		end
	end

	// Receive buffer captured as the done flag sets
	always_ff @(posedge i_clock) begin
		if (i_sys_rst)
			rxbuf <= SPIMC_BYTE_RST;
		else if (fin_now && cap_now)
			rxbuf <= {rx_sh[6:0], sd_in};
		else if (fin_now)
			rxbuf <= rx_sh;
	end

	// Register read data, one cycle after the strobe
	always_ff @(posedge i_clock) begin
		if (i_sys_rst)
			o_rdata <= 8'h00;
		else if (!i_rd)
			o_rdata <= 8'h00;
		else if (i_addr == SPIMC_OFS_DATA)
			o_rdata <= rxbuf;
		else if (i_addr == SPIMC_OFS_CTRL)
			o_rdata <= {irq_en, port_en, half_dis, master,
				idle_lvl, capt_edge, rate};
		else if (i_addr == SPIMC_OFS_STAT)
			o_rdata <= {done_flag, write_collision_flag_flag, 1'b0, mode_fault_flag_flag, 4'h0};
		else
			o_rdata <= 8'h00;
	end

	// Shared interrupt, collision flag excluded
	assign o_irq = irq_en && (done_flag || mode_fault_flag_flag);

	// Pin drivers: clock idle level applied by XOR
	assign o_port_enable = port_en;
	assign o_sck = sck_int ^ idle_lvl;
	assign o_sck_oe = port_en && master;
	assign o_mosi = shreg[7];
	assign o_mosi_oe = port_en && master;
	assign o_miso = shreg[7];
	assign o_miso_oe = port_en && !master && ss_low;
endmodule
`default_nettype wire

//--- verilog/spimc_pkg.sv
// Purpose: Constants for the serial port control/status/data block
// Assumes: 8-bit register port, one 40 MHz clock
// Notes: Offsets are register indices on the plain register port
package spimc_pkg;
	localparam logic [7:0] SPIMC_OFS_DATA = 8'h21;
	localparam logic [7:0] SPIMC_OFS_CTRL = 8'h22;
	localparam logic [7:0] SPIMC_OFS_STAT = 8'h23;
	// Control field positions
	localparam int SPIMC_CR_IRQ_EN = 7;
	localparam int SPIMC_CR_PORT_EN = 6;
	localparam int SPIMC_CR_HALF_DIS = 5;
	localparam int SPIMC_CR_MASTER = 4;
	localparam int SPIMC_CR_IDLE_LVL = 3;
	localparam int SPIMC_CR_CAPT_EDGE = 2;
	localparam int SPIMC_CR_RATE_HI = 1;
	localparam int SPIMC_CR_RATE_LO = 0;
	// Status field positions
	localparam int SPIMC_SR_DONE = 7;
	localparam int SPIMC_SR_WRITE_COLLISION_FLAG = 6;
	localparam int SPIMC_SR_MODE_FAULT_FLAG = 4;
	// Reset values
	localparam logic [3:0] SPIMC_CR_UPPER_RST = 4'h0;
	localparam logic [3:0] SPIMC_CR_LOWER_RST = 4'h0;
	localparam logic [7:0] SPIMC_SR_RST = 8'h00;
	localparam logic [7:0] SPIMC_BYTE_RST = 8'h00;
	localparam logic [3:0] SPIMC_BITS_PER_BYTE = 4'h8;
	typedef enum {SPIMC_IDLE, SPIMC_SHIFT} spimc_state_t;
endpackage
